// File: cca_core.sv
// Counter array capture/compare channels behind an APB slave.
// Assumes channel pins are asynchronous and pass a two-stage synchroniser;
// the counter advances on the timebase tick input.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps

// Function
// - Full 16-bit wrap sets counter overflow flag
// - Cycle-length bit overflow sets intermediate flag
// - Flags set regardless of interrupt enables
// - Each flag gated by its own enable
// - Enabled flags merged, global and array gated
// - Mode bit0 and config bit5 enable interrupts
// - Capture edge selection by mode bits 5,4
// - Capture copies counter, sets channel flag
// - Flags cleared only by software write
// - Software timer match sets channel flag
// - High-speed output toggles pin on match
// - Frequency mode toggles, adds high to low
// - Zero high byte means 256 clocks
// - Frequency mode with match sets flag
// - PWM select bits and cycle length
// - One shared 8-11 bit cycle length
// - Config bit7 steers bytes to reload
// - Comparator off: no toggle, PWM zero
// - PWM match sets flag when bit3 set
// - Invert bit flips output pin only
// - Low write clears, high write sets comparator
// - Counter wraps max to zero, overflow event
module cca_core
    import cca_pkg::*;
#(
    parameter int NCH = 3
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timebase and system interrupt gating
    input wire logic timebase_tick,
    input wire logic global_irq_enable,
    input wire logic array_irq_enable,
    // Channel pins
    input wire logic [NCH-1:0] channel_pin_in,
    output logic [NCH-1:0] channel_pin_out,
    // Interrupt request
    output logic irq
);
    // Counter and shared state
    logic [15:0] counter;
    logic run;
    logic counter_overflow_flag;
    logic overflow_irq_enable;
    logic [7:0] pwm_config_reg;
    logic [NCH-1:0] polarity_reg;
    // Per-channel state
    logic [7:0] channel_mode_reg [NCH];
    logic [15:0] capcmp [NCH];
    logic [15:0] reload [NCH];
    logic [NCH-1:0] channel_event_flag;
    logic [NCH-1:0] out_level;
    // Pin synchroniser and edge history
    logic [NCH-1:0] pin_meta;
    logic [NCH-1:0] pin_sync;
    logic [NCH-1:0] pin_prev;
    // Bus decode, cycle length and counter step and wrap
    logic wr_en;
    logic [1:0] cyc_len;
    logic [15:0] next_counter;
    logic cnt_step;
    logic cnt_wrap;
    logic mid_wrap;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite && clk_en;
    assign cyc_len = pwm_config_reg[1:0];
    assign cnt_step = clk_en && run && timebase_tick;
    assign next_counter = counter + 16'h0001;
    // Wrap at full width
    assign cnt_wrap = cnt_step && (counter == COUNT_MAX);
    // Overflow out of the chosen cycle length bit
    assign mid_wrap = cnt_step && (counter[cyc_len+7] && !next_counter[cyc_len+7]);

    // Channel register address match
    function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [7:0] ofs);
        ch_hit = (a == 8'(ADDR_CH_BASE + 8'(ch) * ADDR_CH_STRIDE + ofs));
    endfunction

    // Low-bits match in PWM at the shared length
    function automatic logic low_match(input logic [15:0] a, input logic [15:0] b,
                                       input logic [1:0] len);
        logic [15:0] m;
        m = 16'hffff >> (4'd8 - {2'b00, len});
        low_match = ((a & m) == (b & m));
    endfunction

    // Two-stage pin synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else if (clk_en) begin
            pin_meta <= channel_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Shared counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= RST_WORD;
        end else if (wr_en && paddr == ADDR_COUNTER) begin
            counter <= pwdata[15:0];
        end else if (cnt_step) begin
            counter <= next_counter;
        end
    end

    // Array control and overflow flags; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            counter_overflow_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
            pwm_config_reg <= RST_BYTE;
            polarity_reg <= '0;
        end else if (clk_en) begin
            if (wr_en && paddr == ADDR_CONTROL) begin
                run <= pwdata[CTL_RUN_BIT];
            end
            // Software write is the only clear
            if (cnt_wrap) begin
                counter_overflow_flag <= 1'b1;
            end else if (wr_en && paddr == ADDR_CONTROL) begin
                counter_overflow_flag <= pwdata[CTL_OVF_BIT];
            end
            if (wr_en && paddr == ADDR_MODE) begin
                overflow_irq_enable <= pwdata[MD_OVF_IRQ_BIT];
            end
            // Config register with intermediate flag
            if (wr_en && paddr == ADDR_PWM_CFG) begin
                pwm_config_reg <= pwdata[7:0];
            end
            if (mid_wrap) begin
                pwm_config_reg[PW_IOVF_FLAG_BIT] <= 1'b1;
            end
            // Polarity takes effect at once
            if (wr_en && paddr == ADDR_POLARITY) begin
                polarity_reg <= pwdata[NCH-1:0];
            end
        end
    end

    // Channel engines
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [7:0] md;
        logic comp_on;
        logic is_cap;
        logic is_pwm;
        logic pwm16;
        logic rise;
        logic fall;
        logic cap_ev;
        logic full_match;
        logic low8_match;
        logic pwm_match;
        logic pwm_ovf;
        logic [8:0] half;
        logic wr_low;
        logic wr_high;
        logic to_reload;

        assign md = channel_mode_reg[i];
        assign comp_on = md[CM_COMP_BIT];
        // Capture selected when bits 6,3,2,1 clear
        assign is_cap = !md[CM_COMP_BIT] && !md[CM_MAT_BIT] && !md[CM_TOG_BIT] &&
                        !md[CM_PWM_BIT];
        // PWM when bit1 set and toggle clear
        assign is_pwm = md[CM_PWM_BIT] && !md[CM_TOG_BIT];
        assign pwm16 = md[CM_PWM16_BIT];
        assign rise = pin_sync[i] && !pin_prev[i];
        assign fall = !pin_sync[i] && pin_prev[i];
        // Edge selection
        assign cap_ev = is_cap && ((md[CM_RISE_BIT] && rise) || (md[CM_FALL_BIT] && fall));
        assign full_match = cnt_step && comp_on && (counter == capcmp[i]);
        assign low8_match = cnt_step && comp_on && (counter[7:0] == capcmp[i][7:0]);
        assign pwm_match = cnt_step && comp_on &&
                           (pwm16 ? (counter == capcmp[i]) : low_match(counter, capcmp[i], cyc_len));
        assign pwm_ovf = pwm16 ? cnt_wrap : mid_wrap;
        // Zero high byte counts as 256
        assign half = (capcmp[i][15:8] == 8'h00) ? HALF_PERIOD_ZERO : {1'b0, capcmp[i][15:8]};
        // Reload steering for 9-11 bit PWM
        assign to_reload = is_pwm && !pwm16 && (cyc_len != 2'b00) &&
                           pwm_config_reg[PW_ARSEL_BIT];
        assign wr_low = wr_en && ch_hit(paddr, i, OFS_CH_LOW);
        assign wr_high = wr_en && ch_hit(paddr, i, OFS_CH_HIGH);

        // Mode register; byte writes move the comparator enable
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                channel_mode_reg[i] <= RST_BYTE;
            end else if (wr_en && ch_hit(paddr, i, OFS_CH_MODE)) begin
                channel_mode_reg[i] <= pwdata[7:0];
            end else if (wr_low && !to_reload) begin
                channel_mode_reg[i][CM_COMP_BIT] <= 1'b0;
            end else if (wr_high && !to_reload) begin
                channel_mode_reg[i][CM_COMP_BIT] <= 1'b1;
            end
        end

        // Capture/compare word and reload word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                capcmp[i] <= RST_WORD;
                reload[i] <= RST_WORD;
            end else if (clk_en) begin
                if (cap_ev) begin
                    // Counter snapshot
                    capcmp[i] <= counter;
                end else if (is_pwm && !comp_on && pwm_ovf) begin
                    capcmp[i] <= capcmp[i];
                end else if (md[CM_PWM_BIT] && md[CM_TOG_BIT] && low8_match) begin
                    // Advance next toggle point
                    capcmp[i][7:0] <= 8'(capcmp[i][7:0] + half);
                end else if (is_pwm && pwm_ovf && !pwm16) begin
                    // Duty update at the overflow edge
                    if (cyc_len == 2'b00) begin
                        capcmp[i][7:0] <= capcmp[i][15:8];
                    end else begin
                        capcmp[i] <= reload[i];
                    end
                end else if (wr_low) begin
                    if (to_reload) begin
                        reload[i][7:0] <= pwdata[7:0];
                    end else begin
                        capcmp[i][7:0] <= pwdata[7:0];
                    end
                end else if (wr_high) begin
                    if (to_reload) begin
                        reload[i][15:8] <= pwdata[7:0];
                    end else begin
                        capcmp[i][15:8] <= pwdata[7:0];
                    end
                end
            end
        end

        // Channel flag: hardware set wins over clear
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                channel_event_flag[i] <= 1'b0;
            end else if (clk_en) begin
                if (cap_ev || (md[CM_MAT_BIT] && !is_pwm && full_match) ||
                    (md[CM_MAT_BIT] && is_pwm && pwm_match)) begin
                    // Capture, timer, output and PWM events
                    channel_event_flag[i] <= 1'b1;
                end else if (wr_en && paddr == ADDR_CONTROL) begin
                    channel_event_flag[i] <= pwdata[i];
                end
            end
        end

        // Output level before inversion
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_level[i] <= 1'b0;
            end else if (clk_en) begin
                if (is_pwm && !comp_on) begin
                    // Comparator off gives 0% duty
                    out_level[i] <= 1'b0;
                end else if (is_pwm && pwm_match) begin
                    out_level[i] <= 1'b1;
                end else if (is_pwm && pwm_ovf) begin
                    out_level[i] <= 1'b0;
                end else if (md[CM_TOG_BIT] && md[CM_PWM_BIT] && low8_match) begin
                    // Square wave toggle
                    out_level[i] <= !out_level[i];
                end else if (md[CM_TOG_BIT] && md[CM_MAT_BIT] && full_match) begin
                    // High-speed toggle; holds when comparator off
                    out_level[i] <= !out_level[i];
                end
            end
        end

        // Inversion applies to the pin output only
        assign channel_pin_out[i] = out_level[i] ^ polarity_reg[i];
    end

    // Interrupt merge
    logic [NCH-1:0] ch_irq_en;
    for (genvar k = 0; k < NCH; k++) begin : g_en
        assign ch_irq_en[k] = channel_mode_reg[k][CM_IRQ_BIT];
    end
    assign irq = global_irq_enable && array_irq_enable &&
                 ((counter_overflow_flag && overflow_irq_enable) ||
                  (pwm_config_reg[PW_IOVF_FLAG_BIT] && pwm_config_reg[PW_IOVF_IRQ_BIT]) ||
                  |(channel_event_flag & ch_irq_en));

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RD_UNMAPPED;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata <= RD_UNMAPPED;
            if (paddr == ADDR_CONTROL) begin
                prdata <= 32'({counter_overflow_flag, run, 6'(channel_event_flag)});
            end else if (paddr == ADDR_MODE) begin
                prdata <= 32'(overflow_irq_enable);
            end else if (paddr == ADDR_PWM_CFG) begin
                prdata <= 32'(pwm_config_reg);
            end else if (paddr == ADDR_POLARITY) begin
                prdata <= 32'(polarity_reg);
            end else if (paddr == ADDR_COUNTER) begin
                prdata <= 32'(counter);
            end
            for (int j = 0; j < NCH; j++) begin
                if (ch_hit(paddr, j, OFS_CH_MODE)) begin
                    prdata <= 32'(channel_mode_reg[j]);
                end
                if (ch_hit(paddr, j, OFS_CH_LOW)) begin
                    prdata <= 32'(capcmp[j][7:0]);
                end
                if (ch_hit(paddr, j, OFS_CH_HIGH)) begin
                    prdata <= 32'(capcmp[j][15:8]);
                end
            end
        end
    end
endmodule

// File: cca_pkg.sv
// Package for the counter array capture/compare block: APB register map,
// field positions, reset values and mode decode constants.
// Assumes a 32-bit APB bus with word-aligned registers.
package cca_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_PWM_CFG = 8'h08;
    localparam logic [7:0] ADDR_POLARITY = 8'h0c;
    localparam logic [7:0] ADDR_COUNTER = 8'h10;
    localparam logic [7:0] ADDR_CH_BASE = 8'h20;
    localparam logic [7:0] ADDR_CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CH_MODE = 8'h00;
    localparam logic [7:0] OFS_CH_LOW = 8'h04;
    localparam logic [7:0] OFS_CH_HIGH = 8'h08;
    // Array control fields
    localparam int CTL_RUN_BIT = 6;
    localparam int CTL_OVF_BIT = 7;
    // Array mode fields
    localparam int MD_OVF_IRQ_BIT = 0;
    // Channel mode fields
    localparam int CM_IRQ_BIT = 0;
    localparam int CM_PWM_BIT = 1;
    localparam int CM_TOG_BIT = 2;
    localparam int CM_MAT_BIT = 3;
    localparam int CM_FALL_BIT = 4;
    localparam int CM_RISE_BIT = 5;
    localparam int CM_COMP_BIT = 6;
    localparam int CM_PWM16_BIT = 7;
    // PWM configuration fields
    localparam int PW_ARSEL_BIT = 7;
    localparam int PW_IOVF_FLAG_BIT = 6;
    localparam int PW_IOVF_IRQ_BIT = 5;
    // Reset values, counter maximum and zero-byte half period
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [8:0] HALF_PERIOD_ZERO = 9'h100;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage

// File: cca_core_checker.sv
// Concurrent checks on the ports of cca_core, attached by bind.
// Assumes full-word APB writes that take effect at the access edge.
`timescale 1ns/100ps
module cca_core_checker
    import cca_pkg::*;
#(
    parameter int NCH = 3
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Timebase, gates, pins and request
    input wire logic timebase_tick,
    input wire logic global_irq_enable,
    input wire logic array_irq_enable,
    input wire logic [NCH-1:0] channel_pin_out,
    input wire logic irq
);
    logic wr;  // Write taken at this edge
    logic step;  // Counter advances at this edge
    logic on;  // Both gates open
    logic run;  // Run bit shadow
    logic wrap;  // Full wrap at the last edge
    logic iwrap;  // Cycle-length wrap at the last edge
    logic ovf_en;  // Overflow enable shadow
    logic iovf_en;  // Intermediate enable shadow
    logic [1:0] len;  // Cycle length shadow
    logic [15:0] cnt;  // Counter shadow
    logic [15:0] lmask;  // Bits below the cycle length
    logic [7:0] mode0;  // Channel 0 mode shadow
    logic [NCH-1:0] pol;  // Polarity shadow
    logic [NCH-1:0] ch_en;  // Channel enable shadow
    assign wr = psel && penable && pwrite && clk_en;
    assign step = clk_en && timebase_tick && run && !(wr && paddr == ADDR_COUNTER);
    assign on = global_irq_enable && array_irq_enable;
    assign lmask = 16'h07ff >> (2'd3 - len);
    // Counter shadow; a bus write overrides a step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= RST_WORD;
            wrap <= 1'b0;
            iwrap <= 1'b0;
        end else begin
            wrap <= step && cnt == COUNT_MAX;
            iwrap <= step && (cnt & lmask) == lmask;
            if (wr && paddr == ADDR_COUNTER) begin
                cnt <= pwdata[15:0];
            end else if (step) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
    // Register shadows taken from bus writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            ovf_en <= 1'b0;
            iovf_en <= 1'b0;
            len <= 2'h0;
            pol <= '0;
            mode0 <= RST_BYTE;
            ch_en <= '0;
        end else if (wr) begin
            if (paddr == ADDR_CONTROL) begin
                run <= pwdata[CTL_RUN_BIT];
            end
            if (paddr == ADDR_MODE) begin
                ovf_en <= pwdata[MD_OVF_IRQ_BIT];
            end
            if (paddr == ADDR_PWM_CFG) begin
                iovf_en <= pwdata[PW_IOVF_IRQ_BIT];
                len <= pwdata[1:0];
            end
            if (paddr == ADDR_POLARITY) begin
                pol <= pwdata[NCH-1:0];
            end
            if (paddr == ADDR_CH_BASE) begin
                mode0 <= pwdata[7:0];
            end
            if (paddr == ADDR_CH_BASE + OFS_CH_LOW) begin
                mode0[CM_COMP_BIT] <= 1'b0;
            end
            if (paddr == ADDR_CH_BASE + OFS_CH_HIGH) begin
                mode0[CM_COMP_BIT] <= 1'b1;
            end
            for (int n = 0; n < NCH; n++) begin
                if (paddr == 8'(ADDR_CH_BASE + ADDR_CH_STRIDE * n)) begin
                    ch_en[n] <= pwdata[CM_IRQ_BIT];
                end
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    irq_gate_a: assert property (!on |-> !irq)
        else $error("irq raised while gated");
    flag_sticky_a: assert property ($fell(irq) && $stable(on) |-> $past(wr))
        else $error("irq dropped without a write");
    ovf_irq_a: assert property (wrap && ovf_en && on |-> ##[0:2] irq)
        else $error("no irq after counter wrap");
    iovf_irq_a: assert property (iwrap && iovf_en && on |-> ##[0:2] irq)
        else $error("no irq after cycle-length wrap");
    enable_need_a: assert property (irq |-> ovf_en || iovf_en || (|ch_en))
        else $error("irq with every enable clear");
    pin_cause_a: assert property (
        $changed(channel_pin_out) |-> $past(timebase_tick && clk_en) || $past(wr))
        else $error("pin moved without tick or write");
    invert_now_a: assert property (
        $past(wr && paddr == ADDR_POLARITY && !timebase_tick)
        |-> channel_pin_out == ($past(channel_pin_out) ^ pol ^ $past(pol)))
        else $error("polarity change not seen at once");
    comp_off_a: assert property (
        $past(!mode0[CM_COMP_BIT] && !mode0[CM_PWM_BIT] && !wr) |-> $stable(channel_pin_out[0]))
        else $error("pin toggled with comparator off");
endmodule

bind cca_core cca_core_checker #(.NCH(NCH)) cca_core_checker_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .timebase_tick(timebase_tick),
    .global_irq_enable(global_irq_enable), .array_irq_enable(array_irq_enable),
    .channel_pin_out(channel_pin_out), .irq(irq));

// File: cca_pin_model.sv
// Far-side model that drives the channel input pins.
// Assumes the bench asks for levels on want; each level stands two clocks.
`timescale 1ns/100ps
module cca_pin_model #(
    parameter int NCH = 3
) (
    // Clock and requested levels
    input wire logic pclk,
    input wire logic [NCH-1:0] want,
    // Pin levels
    output logic [NCH-1:0] pin
);
    logic [NCH-1:0] last;  // Level at the previous edge
    initial begin
        pin = '0;
        last = '0;
    end
    // A level that just changed is held one more clock
    always @(posedge pclk) begin
        last <= pin;
        pin <= (want & ~(pin ^ last)) | (pin & (pin ^ last));
    end
endmodule

// File: cca_core_test.sv
// Self-checking bench for cca_core: APB master, pin model, read scoreboard.
// Assumes a 100 MHz clock and the register map of cca_pkg.
`timescale 1ns/100ps
module cca_core_test
    import cca_pkg::*;
;
    localparam int NCH = 3;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
    logic timebase_tick, global_irq_enable, array_irq_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [NCH-1:0] want, channel_pin_in, channel_pin_out;
    logic [31:0] expq[$];  // Expected read data, oldest first
    logic [15:0] cap;  // Last captured counter value
    int error_cnt, n_checks, i;
    cca_core #(.NCH(NCH)) cca_core_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timebase_tick(timebase_tick),
        .global_irq_enable(global_irq_enable), .array_irq_enable(array_irq_enable),
        .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out), .irq(irq));
    cca_pin_model #(.NCH(NCH)) cca_pin_model_inst (.pclk(pclk), .want(want),
        .pin(channel_pin_in));
    always #5 pclk = ~pclk;
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, then one idle clock
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    function automatic logic [7:0] cha(input int n, input logic [7:0] o);
        return 8'(ADDR_CH_BASE + ADDR_CH_STRIDE * n + o);
    endfunction
    // Pin edge with the counter parked at a random value
    task automatic cap_step(input int n, input logic lvl, input logic hit);
        logic [15:0] r;
        r = 16'($urandom);
        wr(ADDR_COUNTER, {16'h0, r});
        want <= (want & ~(NCH'(1) << n)) | (NCH'(lvl) << n);
        repeat (8) @(posedge pclk);
        if (hit) begin
            cap = r;
        end
        check({31'h0, irq}, {31'h0, hit});
        rd(ADDR_CONTROL, hit ? 32'h1 << n : 32'h0);
        rd(cha(n, OFS_CH_LOW), {24'h0, cap[7:0]});
        rd(cha(n, OFS_CH_HIGH), {24'h0, cap[15:8]});
        wr(ADDR_CONTROL, 32'h0);
    endtask
    // Scoreboard: each completed read takes the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            check(prdata, expq.pop_front());
        end
        // Every completed transfer answers without error
        if (psel && penable && pready) begin
            check({31'h0, pslverr}, 32'h0);
        end
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        report_and_stop;
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, want} = '0;
        {paddr, pwdata} = '0;
        {clk_en, timebase_tick, global_irq_enable, array_irq_enable} = 4'hf;
        pstrb = 4'hf;
        error_cnt = 0;
        n_checks = 0;
        void'($urandom(32'h8bd7));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unmapped holes read as zero
        for (i = 0; i < 20; i++) begin
            rd(8'(i * 4), RD_UNMAPPED);
        end
        // Full counter wrap
        wr(ADDR_MODE, 32'h1);
        wr(ADDR_COUNTER, 32'hfff0);
        wr(ADDR_CONTROL, 32'h40);
        repeat (30) @(posedge pclk);
        rd(ADDR_CONTROL, 32'hc0);
        check({31'h0, irq}, 32'h1);
        global_irq_enable <= 1'b0;
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        global_irq_enable <= 1'b1;
        wr(ADDR_MODE, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd(ADDR_CONTROL, 32'hc0);
        wr(ADDR_CONTROL, 32'h0);
        // Capture: rise on channel 0, fall on 1, both on 2
        for (i = 0; i < NCH; i++) begin
            cap = 16'h0;
            wr(cha(i, OFS_CH_LOW), 32'h0);
            wr(cha(i, OFS_CH_HIGH), 32'h0);
            wr(cha(i, OFS_CH_MODE), (i == 0) ? 32'h21 : (i == 1) ? 32'h11 : 32'h31);
            cap_step(i, 1'b1, i != 1);
            cap_step(i, 1'b0, i != 0);
        end
        // High-speed output on channel 0
        wr(cha(0, OFS_CH_MODE), 32'h0c);
        wr(cha(0, OFS_CH_LOW), 32'h38);
        wr(cha(0, OFS_CH_HIGH), 32'h12);
        rd(cha(0, OFS_CH_MODE), 32'h4c);
        wr(ADDR_COUNTER, 32'h1230);
        wr(ADDR_CONTROL, 32'h40);
        repeat (20) @(posedge pclk);
        check(32'(channel_pin_out), 32'h1);
        rd(ADDR_CONTROL, 32'h41);
        timebase_tick <= 1'b0;
        wr(ADDR_POLARITY, 32'h1);
        check(32'(channel_pin_out), 32'h0);
        wr(ADDR_POLARITY, 32'h0);
        timebase_tick <= 1'b1;
        wr(cha(0, OFS_CH_LOW), 32'h40);
        rd(cha(0, OFS_CH_MODE), 32'h0c);
        wr(ADDR_COUNTER, 32'h123e);
        wr(ADDR_CONTROL, 32'h40);
        repeat (20) @(posedge pclk);
        check(32'(channel_pin_out), 32'h1);
        rd(ADDR_CONTROL, 32'h40);
        wr(ADDR_CONTROL, 32'h0);
        // Intermediate overflow at each cycle length
        for (i = 0; i < 8; i++) begin
            wr(ADDR_PWM_CFG, 32'h20 | (i % 4));
            wr(ADDR_COUNTER, (i < 4) ? (32'h100 << i) - 32'h4 : 32'hfc);
            wr(ADDR_CONTROL, 32'h40);
            repeat (10) @(posedge pclk);
            check({31'h0, irq}, {31'h0, i <= 4});
            rd(ADDR_PWM_CFG, 32'h20 | (i % 4) | ((i <= 4) ? 32'h40 : 32'h0));
            wr(ADDR_CONTROL, 32'h0);
            wr(ADDR_PWM_CFG, 32'h0);
        end
        // 8-bit PWM with match flag on channel 2, square wave on channel 1
        wr(cha(2, OFS_CH_MODE), 32'h0a);
        wr(cha(2, OFS_CH_LOW), 32'h10);
        wr(cha(2, OFS_CH_HIGH), 32'h10);
        wr(cha(1, OFS_CH_MODE), 32'h06);
        wr(cha(1, OFS_CH_LOW), 32'h10);
        wr(cha(1, OFS_CH_HIGH), 32'h04);
        wr(ADDR_COUNTER, 32'h0);
        wr(ADDR_CONTROL, 32'h40);
        // Counter ends at 0x1a: toggles at 0x10, 0x14 and 0x18
        repeat (25) @(posedge pclk);
        timebase_tick <= 1'b0;
        rd(cha(1, OFS_CH_LOW), 32'h1c);
        rd(cha(2, OFS_CH_MODE), 32'h4a);
        rd(ADDR_CONTROL, 32'h44);
        check(32'(channel_pin_out), 32'h7);
        timebase_tick <= 1'b1;
        wr(ADDR_CONTROL, 32'h0);
        report_and_stop;
    end
endmodule
